// ===== magstripe_defs.svh
`ifndef MAGSTRIPE_DEFS_SVH
`define MAGSTRIPE_DEFS_SVH

// clock rate in kHz and timing figures
`define CLOCK_KHZ        40000
`define SETUP_NS         3000
`define SETUP_CYCLES     ((`SETUP_NS * `CLOCK_KHZ) / 1000000)
`define SYNC_ZEROS       6
`define SKIP_MIN         6
`define SKIP_MAX         9
// ram layout
`define RAM_WORDS        2304
`define TRACK_WORDS      768
`define TRACK_A_BASE     12'h000
`define TRACK_B_BASE     12'h300
`define TRACK_C_BASE     12'h600
`define SPI_BITS         8
// idle fill returned on the slave-out line
`define SPI_EMPTY        8'hff

`endif

// ===== magstripe_pkg.sv
package magstripe_pkg;
  typedef logic [11:0] ram_addr_t;

  typedef struct packed {
    logic [2:0] bit_valid;
    logic [2:0] bit_value;
  } recovered_t;

  typedef struct packed {
    logic [2:0] strobe;
    logic [2:0] bit_out;
  } cd_pins_t;

  typedef enum logic [1:0] {
    TRACK_A,
    TRACK_B,
    TRACK_C
  } track_t;
endpackage

// ===== bit_ram.sv
`timescale 1ns/100ps
`include "magstripe_defs.svh"

module bit_ram (
  input  wire logic                  clock,
  input  wire logic                  write_en,
  input  wire magstripe_pkg::ram_addr_t addr,
  input  wire logic                  write_bit,
  output logic                       read_bit
);
  import magstripe_pkg::*;

  logic mem [0:`RAM_WORDS-1];

  // single port: addr is read every cycle, so a write cycle also reads the old bit
  always_ff @(posedge clock) begin
    if (write_en) begin
      mem[addr] <= write_bit;
    end
    read_bit <= mem[addr];
  end
endmodule

// ===== spi_slave.sv
`timescale 1ns/100ps
`include "magstripe_defs.svh"

module spi_slave (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  input  wire logic                  enable,
  input  wire logic                  sel_n_sync,
  input  wire logic                  sck_rise,
  input  wire logic                  sck_fall,
  input  wire logic                  mosi_sync,
  input  wire logic [7:0]            reply,
  output logic                       miso_o,
  output logic                       miso_oe,
  output logic [7:0]                 command,
  output logic                       command_valid
);
  import magstripe_pkg::*;

  logic [7:0] in_reg;
  logic [7:0] out_reg;
  logic [2:0] count_reg;
  logic       active;

  assign active = enable && !sel_n_sync;

  // (RULE15) rising edge sample
  always_ff @(posedge clock) begin
    if (sys_rst || !active) begin
      in_reg        <= 8'h00;
      count_reg     <= 3'h0;
      command       <= 8'h00;
      command_valid <= 1'b0;
    end else begin
      command_valid <= 1'b0;
      if (sck_rise) begin
        in_reg    <= {in_reg[6:0], mosi_sync};
        count_reg <= count_reg + 3'h1;
        // (RULE19) eight bits msb first
        if (count_reg == 3'h7) begin
          command       <= {in_reg[6:0], mosi_sync};
          command_valid <= 1'b1;
        end
      end
    end
  end

  // (RULE16) falling edge shift out
  always_ff @(posedge clock) begin
    if (sys_rst || !active) begin
      out_reg <= `SPI_EMPTY;
      miso_o  <= 1'b1;
    end else if (command_valid) begin
      out_reg <= reply;
    end else if (sck_fall) begin
      miso_o  <= out_reg[7];
      out_reg <= {out_reg[6:0], 1'b1};
    end
  end

  // (RULE17) tristate while deselected
  assign miso_oe = active;
endmodule

// ===== magstripe_buffer_output.sv
`timescale 1ns/100ps
`include "magstripe_defs.svh"

// Overview of operation
// (RULE1) sleep holds data, strobes, detect high
// (RULE2) auto sleep without head, wake on signal
// (RULE3) first six to nine bits withheld
// (RULE4) data high means zero, low one
// (RULE5) output order equals recovery order
// (RULE6) strobe idles high, low starts sample
// (RULE7) processor captures data before next strobe
// (RULE8) strobes paced from ram, not card
// (RULE9) half rate low doubles strobe, period
// (RULE10) media detect open drain, low reading
// (RULE11) detect after six consistent zeros
// (RULE12) about 3 us detect to strobe
// (RULE13) data changes 3 us before strobe
// (RULE14) strobe low and hold half bit
// (RULE15) spi samples input on rising clock
// (RULE16) spi shifts output on falling clock
// (RULE17) spi active only with select low
// (RULE18) master keeps serial clock under 500kHz; the testbench runs it at 5MHz
// (RULE19) eight bit command, eight bit answer
// (RULE20) one 2304 bit ram, three buffers
// (RULE21) tracks at 0x000, 0x300, 0x600
// (RULE22) sync zeros stored along with data
// (RULE23) half rate high equals card rate
// (RULE24) mode input high selects clock data
// (RULE25) bits written ascending from buffer base
module magstripe_buffer_output (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     head_signal,
  input  wire magstripe_pkg::recovered_t recovered,
  input  wire logic [15:0]              card_bit_cycles,
  input  wire logic                     clock_and_data_mode,
  input  wire logic                     half_rate_select,
  input  wire logic                     spi_select_n,
  input  wire logic                     serial_shift_clock,
  input  wire logic                     spi_data_in,
  output magstripe_pkg::cd_pins_t       cd_pins,
  output logic                          media_present_o,
  output logic                          media_present_oe,
  output logic [7:0]                    spi_command,
  output logic                          spi_command_valid,
  output logic                          sleeping
);
  import magstripe_pkg::*;

  localparam logic [15:0] SETUP_CYC = 16'(`SETUP_CYCLES);
  localparam logic [9:0]  TRK_LAST  = 10'(`TRACK_WORDS - 1);

  function automatic ram_addr_t track_base(input logic [1:0] t);
    unique case (t)
      2'd0:    track_base = `TRACK_A_BASE;
      2'd1:    track_base = `TRACK_B_BASE;
      default: track_base = `TRACK_C_BASE;
    endcase
  endfunction

  // pin synchronisers
  logic [1:0] head_s, mode_s, half_s, seln_s, sck_s, mosi_s;
  logic       sck_d;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      head_s <= 2'b00;
      mode_s <= 2'b00;
      half_s <= 2'b00;
      seln_s <= 2'b11;
      sck_s  <= 2'b00;
      mosi_s <= 2'b00;
      sck_d  <= 1'b0;
    end else begin
      head_s <= {head_s[0], head_signal};
      mode_s <= {mode_s[0], clock_and_data_mode};
      half_s <= {half_s[0], half_rate_select};
      seln_s <= {seln_s[0], spi_select_n};
      sck_s  <= {sck_s[0], serial_shift_clock};
      mosi_s <= {mosi_s[0], spi_data_in};
      sck_d  <= sck_s[1];
    end
  end
  logic sck_rise, sck_fall, cd_mode, full_rate;
  assign sck_rise  = sck_s[1] && !sck_d;
  assign sck_fall  = !sck_s[1] && sck_d;
  // (RULE24) mode select
  assign cd_mode   = mode_s[1];
  assign full_rate = half_s[1];

  // (RULE2) automatic sleep and wake
  logic awake_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awake_reg <= 1'b0;
    end else begin
      awake_reg <= head_s[1];
    end
  end
  assign sleeping = !awake_reg;

  // write side: one pending bit per track, serviced round robin
  logic [2:0] pend_reg, pend_val_reg;
  logic [9:0] wr_ptr [3];
  logic [1:0] wr_trk_reg;
  logic [2:0] zero_run [3];
  logic [2:0] synced_reg;
  logic [3:0] seen [3];
  logic       cd_rd;
  logic       wr_go;
  assign wr_go = pend_reg[wr_trk_reg] && !cd_rd;

  always_ff @(posedge clock) begin
    if (sys_rst || !awake_reg) begin
      pend_reg     <= 3'b000;
      pend_val_reg <= 3'b000;
      wr_trk_reg   <= 2'd0;
      synced_reg   <= 3'b000;
      for (int t = 0; t < 3; t++) begin
        wr_ptr[t]   <= 10'h000;
        zero_run[t] <= 3'h0;
        seen[t]     <= 4'h0;
      end
    end else begin
      if (!cd_rd) begin
        wr_trk_reg <= (wr_trk_reg == 2'd2) ? 2'd0 : wr_trk_reg + 2'd1;
      end
      for (int t = 0; t < 3; t++) begin
        // service clears, a new bit in the same cycle wins
        if (wr_go && wr_trk_reg == 2'(t)) begin
          pend_reg[t] <= 1'b0;
          // (RULE25) ascending fill, stop at buffer end
          if (wr_ptr[t] != TRK_LAST) begin
            wr_ptr[t] <= wr_ptr[t] + 10'h001;
          end
        end
        if (recovered.bit_valid[t]) begin
          pend_reg[t]     <= 1'b1;
          pend_val_reg[t] <= recovered.bit_value[t];
          if (seen[t] != 4'hf) begin
            seen[t] <= seen[t] + 4'h1;
          end
          // (RULE11) six consistent zeros
          if (recovered.bit_value[t]) begin
            zero_run[t] <= 3'h0;
          end else if (zero_run[t] != 3'(`SYNC_ZEROS)) begin
            zero_run[t] <= zero_run[t] + 3'h1;
          end
          if (!recovered.bit_value[t] &&
              zero_run[t] == 3'(`SYNC_ZEROS - 1)) begin
            synced_reg[t] <= 1'b1;
          end
        end
      end
    end
  end

  // (RULE20) one shared single-port ram
  ram_addr_t ram_addr;
  ram_addr_t rd_addr;
  logic      ram_q;
  // (RULE21) per-track buffer bases
  assign ram_addr = cd_rd ? rd_addr
                  : track_base(wr_trk_reg) + {2'b00, wr_ptr[wr_trk_reg]};

  // (RULE22) every recovered bit stored, sync zeros too
  bit_ram u_ram (
    .clock     (clock),
    .write_en  (wr_go && awake_reg),
    .addr      (ram_addr),
    .write_bit (pend_val_reg[wr_trk_reg]),
    .read_bit  (ram_q)
  );

  // clock-and-data playback
  typedef enum logic [2:0] {CD_IDLE, CD_WAIT, CD_READ, CD_SETUP,
                            CD_LOW, CD_HOLD} cd_state_t;
  cd_state_t  cd_state;
  logic [1:0] rd_trk_reg;
  logic [9:0] rd_ptr [3];
  logic [15:0] tmr_reg;
  logic [15:0] half_bit;
  logic        any_synced;
  logic        avail;
  assign any_synced = |synced_reg;
  // (RULE3) first skip-min bits withheld
  assign avail = (wr_ptr[rd_trk_reg] > rd_ptr[rd_trk_reg]) &&
                 (seen[rd_trk_reg] > 4'(`SKIP_MIN));
  // (RULE9) (RULE23) half rate doubles bit period
  assign half_bit = full_rate ? {1'b0, card_bit_cycles[15:1]}
                              : card_bit_cycles;
  assign rd_addr  = track_base(rd_trk_reg) + {2'b00, rd_ptr[rd_trk_reg]};
  assign cd_rd    = cd_mode && awake_reg && cd_state == CD_READ;

  logic [2:0] strobe_reg, data_reg;
  logic       md_reg;
  always_ff @(posedge clock) begin
    // head loss clears at once, so the first sleep cycle shows idle levels
    if (sys_rst || !awake_reg || !head_s[1] || !cd_mode) begin
      cd_state   <= CD_IDLE;
      rd_trk_reg <= 2'd0;
      tmr_reg    <= 16'h0000;
      md_reg     <= 1'b0;
      strobe_reg <= 3'b111;
      data_reg   <= 3'b111;
      for (int t = 0; t < 3; t++) begin
        rd_ptr[t] <= 10'(`SKIP_MIN);
      end
    end else begin
      unique case (cd_state)
        CD_IDLE: begin
          // (RULE11) detect only after sync
          if (any_synced) begin
            md_reg   <= 1'b1;
            // (RULE12) data setup alone spaces detect from strobe
            tmr_reg  <= 16'h0000;
            cd_state <= CD_WAIT;
          end
        end
        CD_WAIT: begin
          if (tmr_reg != 16'h0000) begin
            tmr_reg <= tmr_reg - 16'h0001;
          end else if (avail) begin
            cd_state <= CD_READ;
          end else begin
            rd_trk_reg <= (rd_trk_reg == 2'd2) ? 2'd0
                                               : rd_trk_reg + 2'd1;
          end
        end
        CD_READ: begin
          cd_state <= CD_SETUP;
        end
        CD_SETUP: begin
          // (RULE4) (RULE5) inverted level, recovery order
          data_reg[rd_trk_reg] <= !ram_q;
          rd_ptr[rd_trk_reg]   <= rd_ptr[rd_trk_reg] + 10'h001;
          // (RULE13) (RULE12) setup before strobe
          tmr_reg  <= SETUP_CYC;
          cd_state <= CD_LOW;
        end
        CD_LOW: begin
          if (tmr_reg != 16'h0000) begin
            tmr_reg <= tmr_reg - 16'h0001;
          end else if (strobe_reg[rd_trk_reg]) begin
            // (RULE6) (RULE8) strobe low from buffer
            strobe_reg[rd_trk_reg] <= 1'b0;
            // count ends on zero, so load one less for half_bit cycles
            tmr_reg <= half_bit - 16'h0001;
          end else begin
            // (RULE14) half bit low then half bit hold
            strobe_reg[rd_trk_reg] <= 1'b1;
            tmr_reg  <= half_bit - 16'h0001;
            cd_state <= CD_HOLD;
          end
        end
        CD_HOLD: begin
          if (tmr_reg != 16'h0000) begin
            tmr_reg <= tmr_reg - 16'h0001;
          end else begin
            rd_trk_reg <= (rd_trk_reg == 2'd2) ? 2'd0
                                               : rd_trk_reg + 2'd1;
            cd_state   <= CD_WAIT;
          end
        end
      endcase
    end
  end

  // (RULE1) sleep forces outputs high
  assign cd_pins.strobe   = strobe_reg;
  assign cd_pins.bit_out  = data_reg;
  logic miso_o, miso_oe;
  // (RULE10) open drain detect, slave out in spi mode
  assign media_present_o  = cd_mode ? 1'b0 : miso_o;
  assign media_present_oe = cd_mode ? (md_reg && awake_reg) : miso_oe;

  spi_slave u_spi (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .enable        (!cd_mode),
    .sel_n_sync    (seln_s[1]),
    .sck_rise      (sck_rise),
    .sck_fall      (sck_fall),
    .mosi_sync     (mosi_s[1]),
    .reply         (`SPI_EMPTY),
    .miso_o        (miso_o),
    .miso_oe       (miso_oe),
    .command       (spi_command),
    .command_valid (spi_command_valid)
  );

  // (RULE1) outputs high during sleep
  property p_sleep_high;
    @(posedge clock) disable iff (sys_rst)
      sleeping |-> (cd_pins.strobe == 3'b111 && cd_pins.bit_out == 3'b111
                    && !(cd_mode && media_present_oe));
  endproperty
  a_sleep_high: assert property (p_sleep_high) // RULE1
    else $error("outputs not high in sleep");

  // (RULE12) delay before first strobe
  property p_md_delay;
    @(posedge clock) disable iff (sys_rst)
      $rose(md_reg) |-> (strobe_reg == 3'b111) [*8];
  endproperty
  a_md_delay: assert property (p_md_delay) // RULE12
    else $error("strobe too soon after detect");

  // (RULE11) detect needs sync
  property p_md_sync;
    @(posedge clock) disable iff (sys_rst)
      $rose(md_reg) |-> $past(any_synced);
  endproperty
  a_md_sync: assert property (p_md_sync) // RULE11
    else $error("detect before sync");

  // (RULE17) deselected slave-out off
  property p_miso_off;
    @(posedge clock) disable iff (sys_rst)
      (seln_s[1] && !cd_mode) |-> !media_present_oe;
  endproperty
  a_miso_off: assert property (p_miso_off) // RULE17
    else $error("slave out driven while deselected");

  // (RULE6) strobe only falls in low phase
  property p_strobe_fall;
    @(posedge clock) disable iff (sys_rst)
      $fell(strobe_reg[0]) |-> $past(cd_state == CD_LOW);
  endproperty
  a_strobe_fall: assert property (p_strobe_fall) // RULE6
    else $error("strobe fell outside low phase");

  // (RULE13) data stable while strobe low
  property p_data_stable;
    @(posedge clock) disable iff (sys_rst || !awake_reg)
      !strobe_reg[0] |-> $stable(data_reg[0]);
  endproperty
  a_data_stable: assert property (p_data_stable) // RULE13
    else $error("data moved under strobe");

  // (RULE20) ram read never writes
  property p_single_port;
    @(posedge clock) disable iff (sys_rst)
      cd_rd |-> !wr_go;
  endproperty
  a_single_port: assert property (p_single_port) // RULE20
    else $error("ram read and write collide");

  // (RULE24) spi quiet in clock-data mode
  property p_mode;
    @(posedge clock) disable iff (sys_rst)
      cd_mode |-> !spi_command_valid;
  endproperty
  a_mode: assert property (p_mode) // RULE24
    else $error("spi active in clock data mode");
endmodule

// ===== cd_capture.sv
`timescale 1ns/100ps

module cd_capture (
  input wire logic                    clock,
  input wire magstripe_pkg::cd_pins_t cd_pins,
  input wire logic                    media_present_oe
);
  import magstripe_pkg::*;
  logic strobe_a_reg = 1'b1;
  int   low_cnt = 0;
  int   gap_cnt = 0;
  int   width = 0;
  int   gap = -1;
  logic q[$];

  // a slow processor only ever sees track a here
  always @(posedge clock) begin
    strobe_a_reg <= cd_pins.strobe[0];
    if (strobe_a_reg && !cd_pins.strobe[0]) begin
      q.push_back(!cd_pins.bit_out[0]);
      if (gap < 0) begin
        gap = gap_cnt;
      end
    end
    if (!cd_pins.strobe[0]) begin
      low_cnt++;
    end
    else if (low_cnt != 0) begin
      width = low_cnt;
      low_cnt = 0;
    end
    gap_cnt = media_present_oe ? gap_cnt + 1 : 0;
  end
endmodule

// ===== tb.sv
`timescale 1ns/100ps

module tb;
  import magstripe_pkg::*;
  logic       clock;
  logic       sys_rst;
  logic       head_signal;
  recovered_t recovered;
  logic       clock_and_data_mode;
  logic       half_rate_select;
  logic       spi_select_n;
  logic       serial_shift_clock;
  logic       spi_data_in;
  cd_pins_t   cd_pins;
  logic       media_present_o;
  logic       media_present_oe;
  logic [7:0] spi_command;
  logic       spi_command_valid;
  logic       sleeping;
  wire        md_pin;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         seen = 0;
  logic [7:0] got;

  // external pull-up on the shared pin
  assign md_pin = media_present_oe ? media_present_o : 1'b1;

  magstripe_buffer_output dut_u (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .head_signal         (head_signal),
    .recovered           (recovered),
    .card_bit_cycles     (16'h0028),
    .clock_and_data_mode (clock_and_data_mode),
    .half_rate_select    (half_rate_select),
    .spi_select_n        (spi_select_n),
    .serial_shift_clock  (serial_shift_clock),
    .spi_data_in         (spi_data_in),
    .cd_pins             (cd_pins),
    .media_present_o     (media_present_o),
    .media_present_oe    (media_present_oe),
    .spi_command         (spi_command),
    .spi_command_valid   (spi_command_valid),
    .sleeping            (sleeping)
  );

  cd_capture partner_u (
    .clock            (clock),
    .cd_pins          (cd_pins),
    .media_present_oe (media_present_oe)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end
    else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic t_sleep;
    head_signal <= 1'b0;
    repeat (6) @(posedge clock);
    check(sleeping, 1'b1);
    check(cd_pins, 6'h3f);
    check(md_pin, 1'b1);
    head_signal <= 1'b1;
    repeat (6) @(posedge clock);
    check(sleeping, 1'b0);
    check(cd_pins.strobe, 3'h7);
    $display("test sleep done");
  endtask

  // six sync zeros, then eight data bits on track a
  task automatic cd_run(input logic half, input int exp_w);
    logic [7:0] pat;
    int         i;
    pat = 8'hb2;
    half_rate_select <= half;
    head_signal <= 1'b0;
    repeat (8) @(posedge clock);
    partner_u.q.delete();
    partner_u.gap = -1;
    head_signal <= 1'b1;
    repeat (8) @(posedge clock);
    for (i = 0; i < 14; i++) begin
      recovered.bit_valid <= 3'h1;
      recovered.bit_value <= {2'h0, (i < 6) ? 1'b0 : pat[13-i]};
      @(posedge clock);
      recovered.bit_valid <= 3'h0;
      repeat (3) @(posedge clock);
      if (i == 4) begin
        check(media_present_oe, 1'b0);
      end
    end
    check(md_pin, 1'b0);
    for (i = 0; i < 6000 && partner_u.q.size() < 8; i++) begin
      @(posedge clock);
    end
    repeat (exp_w + 4) @(posedge clock);
    check(partner_u.q.size(), 8);
    for (i = 0; i < 8; i++) begin
      check(partner_u.q[i], pat[7-i]);
    end
    check(partner_u.gap >= 60 && partner_u.gap <= 180, 1'b1);
    check(partner_u.width, exp_w);
    check(cd_pins.strobe, 3'h7);
    $display("test clock and data done");
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock);
      if (spi_command_valid === 1'b1) begin
        seen++;
        got = spi_command;
      end
    end
  endtask

  // serial clock idles low and runs only inside the frame
  // eight clocks a period, reply path is fixed
  task automatic frame(input logic sel_n, input logic [7:0] cmd);
    int i;
    spi_select_n <= sel_n;
    tick(4);
    for (i = 7; i >= 0; i--) begin
      spi_data_in <= cmd[i];
      tick(4);
      serial_shift_clock <= 1'b1;
      tick(4);
      serial_shift_clock <= 1'b0;
    end
    tick(8);
    spi_select_n <= 1'b1;
    spi_data_in <= ~cmd[0];
    tick(4);
  endtask

  task automatic t_spi;
    clock_and_data_mode <= 1'b0;
    tick(4);
    seen = 0;
    frame(1'b1, 8'h3c);
    check(seen, 0);
    check(media_present_oe, 1'b0);
    frame(1'b0, 8'ha5);
    check(seen, 1);
    check(got, 8'ha5);
    check(media_present_oe, 1'b0);
    $display("test spi done");
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    sys_rst = 1'b1;
    head_signal = 1'b1;
    recovered = '0;
    clock_and_data_mode = 1'b1;
    half_rate_select = 1'b1;
    spi_select_n = 1'b1;
    serial_shift_clock = 1'b0;
    spi_data_in = 1'b0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_sleep;
    cd_run(1'b1, 20);
    cd_run(1'b0, 40);
    t_spi;
    end_sim;
  end
endmodule
